// ### pkg/dpsf_pkg.sv
// Package for the host-side token semaphore controller
package dpsf_pkg;
  // ****************************************
  // Sizes and encodings
  // ****************************************
  localparam int unsigned TOKEN_COUNT = 8;
  localparam int unsigned INDEX_WIDTH = 3;
  localparam int unsigned DATA_WIDTH = 16;
  localparam logic FLAG_TAKEN = 1'b0;
  localparam logic FLAG_FREE = 1'b1;
  // ****************************************
  // Pin timing, cycles of sys_clk at 200 MHz
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STROBE_NS = 40;
  localparam int unsigned GAP_NS = 20;
  localparam logic [3:0] STROBE_CYCLES = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] GAP_CYCLES = 4'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] COUNT_RESET = 4'h0;

  typedef enum logic [1:0] {
    OP_ACQUIRE,
    OP_RELEASE,
    OP_POLL,
    OP_INIT
  } dpsf_op_type;

  typedef struct packed {
    dpsf_op_type op;
    logic [INDEX_WIDTH-1:0] index;
  } dpsf_cmd_type;

  typedef struct packed {
    logic token_space_select_n;
    logic output_enable_n;
    logic read_write_n;
    logic [INDEX_WIDTH-1:0] token_index;
  } dpsf_pins_type;

  localparam dpsf_pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 3'h0};
endpackage

// ### testbench/dpsf_host_assertions.sv
// Host pin protocol checker
`timescale 1ns/100ps
`default_nettype none
module dpsf_host_assertions import dpsf_pkg::*; (
  // Watched ports
  input wire logic sys_clk, sys_rst, cmd_valid, cmd_ready, data_oe,
  input wire dpsf_cmd_type cmd,
  input wire dpsf_pins_type pins,
  input wire logic [DATA_WIDTH-1:0] data_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic go = cmd_valid && cmd_ready;
  chk_wr_bits: assert property (data_oe |-> data_out[15:1] == 15'h0) else $error("bad word");
  chk_wr_sel: assert property (data_oe |-> !pins.token_space_select_n && !pins.read_write_n)
    else $error("bad write strobe");
  // Pins are registered one cycle behind the state, so the strobe starts two edges after take
  chk_acq_order: assert property (go && cmd.op == OP_ACQUIRE |=>
    !data_oe ##1 data_oe [*8] ##1 (!data_oe) [*4]
    ##1 (!pins.output_enable_n) [*8]) else $error("bad acquire");
  chk_rel_one: assert property (go && cmd.op == OP_RELEASE |=>
    !data_oe ##1 (data_oe && data_out[0])) else $error("bad release");
  chk_read_gap: assert property ($rose(pins.output_enable_n) |-> pins.output_enable_n [*4])
    else $error("reads too close");
  chk_init_one: assert property (go && cmd.op == OP_INIT |=>
    !data_oe ##1 (data_oe && data_out[0])) else $error("bad init");
endmodule
bind dpsf_host dpsf_host_assertions chk (.sys_clk, .sys_rst, .cmd_valid, .cmd_ready, .data_oe,
  .cmd, .pins, .data_out);
`default_nettype wire

// ### testbench/dpsf_host_tb.sv
// Bench for the token host against the token model
`timescale 1ns/100ps
`default_nettype none
module dpsf_host_tb import dpsf_pkg::*; ;
  logic sys_clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, cmd_ready, done, granted, data_oe, r_flag;
  logic [4:0] r_wr = 5'h01;
  logic [15:0] read_word, data_out, data_in;
  dpsf_cmd_type cmd = '0;
  dpsf_pins_type pins;
  int err_count = 0, comparisons = 0, cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  dpsf_host uut (.sys_clk, .sys_rst, .cmd_valid, .cmd, .cmd_ready, .done, .granted,
    .read_word, .pins, .data_out, .data_oe, .data_in);
  dpsf_token_model dev (.sys_clk, .pins, .data_out, .data_oe, .data_in, .r_wr, .r_flag);
  task automatic ck(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    err_count += int'(g !== e);
    if (g !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, g);
  endtask
  // Command is up for one edge only, without waiting for ready; n counts strobe-and-gap slots
  task automatic run(dpsf_op_type op, logic [2:0] i, int n);
    int k = 0;
    @(posedge sys_clk) {cmd_valid, cmd} <= {1'b1, op, i};
    @(posedge sys_clk) cmd_valid <= 1'b0;
    #1 ck("busy", 16'h0, 16'(cmd_ready));
    while (k < 200 && done !== 1'b1) begin
      @(posedge sys_clk) #1;
      k++;
    end
    // A wait that runs out shows up as a wrong cycle count
    ck("cycles", 16'(n * int'(STROBE_CYCLES + GAP_CYCLES)), 16'(k));
    ck("ready", 16'h1, 16'(cmd_ready));
  endtask
  task automatic rw(logic [2:0] i, logic b);
    @(posedge sys_clk) r_wr <= {1'b1, i, b};
    @(posedge sys_clk) r_wr[4] <= 1'b0;
    #1;
  endtask
  task automatic t_claim;
    run(OP_INIT, 3'h0, 8);
    for (int i = 0; i < 8; i++) rw(3'(i), 1'b1);
    run(OP_ACQUIRE, 3'h5, 2);
    ck("claim", 16'h0, read_word);
    rw(3'h5, 1'b0);
    ck("pending", 16'h1, 16'(r_flag));
    run(OP_RELEASE, 3'h5, 1);
    ck("passed", 16'h0, 16'(r_flag));
    run(OP_ACQUIRE, 3'h5, 2);
    ck("lost", 16'hffff, read_word);
    ck("lost_granted", 16'h0, 16'(granted));
    rw(3'h5, 1'b1);
    run(OP_POLL, 3'h5, 1);
    ck("won", 16'h1, 16'(granted));
    $display("t_claim done");
  endtask
  // Reset in mid-write drops the pins at once; software then frees every token again
  task automatic t_reset;
    @(posedge sys_clk) {cmd_valid, cmd} <= {1'b1, OP_ACQUIRE, 3'h2};
    @(posedge sys_clk) cmd_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk) #1;
    ck("rst_pins", 16'(PINS_IDLE), 16'(pins));
    ck("rst_oe", 16'h0, 16'(data_oe));
    ck("rst_granted", 16'h0, 16'(granted));
    ck("rst_ready", 16'h1, 16'(cmd_ready));
    run(OP_INIT, 3'h0, 8);
    run(OP_POLL, 3'h2, 1);
    ck("freed", 16'hffff, read_word);
    $display("t_reset done");
  endtask
  task automatic test_done(int extra);
    err_count += extra;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cycles == 1000) test_done(1);
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_claim();
    t_reset();
    test_done(0);
  end
endmodule
`default_nettype wire

// ### testbench/dpsf_token_model.sv
// Two-port token device model
`timescale 1ns/100ps
`default_nettype none
module dpsf_token_model import dpsf_pkg::*; (
  // Near port pins; far port {write, index, bit} and its flag
  input wire logic sys_clk, data_oe,
  input wire dpsf_pins_type pins,
  input wire logic [15:0] data_out,
  input wire logic [4:0] r_wr,
  output logic [15:0] data_in,
  output logic r_flag
);
  logic [7:0] req_l, req_r, own_l = '0, own_r = '0;
  logic [15:0] q = '0;
  logic held = 1'b0;
  wire logic rd = !pins.token_space_select_n && !pins.output_enable_n;
  assign r_flag = !own_r[r_wr[3:1]];
  // Bus shows the inverted flag for one access cycle, then shows the frozen flag
  assign data_in = (rd && held) ? q : ~q;
  always @(posedge sys_clk) begin
    if (data_oe && !pins.read_write_n) req_l[pins.token_index] = data_out[0];
    if (r_wr[4]) req_r[r_wr[3:1]] = r_wr[0];
    for (int i = 0; i < 8; i++) begin
      if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
      if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
      // Near side wins a tie
      if (!own_l[i] && !own_r[i] && !req_l[i]) own_l[i] = 1'b1;
      if (!own_l[i] && !own_r[i] && !req_r[i]) own_r[i] = 1'b1;
    end
    // Latch with the index seen under the strobe, frozen until the strobe drops
    if (!held) q <= {16{!own_l[pins.token_index]}};
    held <= rd;
  end
endmodule
`default_nettype wire

// ### verilog/dpsf_host.sv
// Host-side controller that claims and frees semaphore tokens over one port's pins
// Function
// - Write zero requests, write one releases
// - Select low token space, SRAM-like strobes
// - Write zero first, then read back
// - Failed request: poll or withdraw with one
// - Drop select between successive reads
// - No self-init; write one to all tokens
`timescale 1ns/100ps
`default_nettype none
module dpsf_host
  import dpsf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire dpsf_cmd_type cmd,
  output logic cmd_ready,
  output logic done,
  output logic granted,
  output logic [DATA_WIDTH-1:0] read_word,
  // Device pins of one port
  output dpsf_pins_type pins,
  output logic [DATA_WIDTH-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_WIDTH-1:0] data_in
);
  // ****************************************
  // Input synchroniser
  // ****************************************
  // The far port runs on its own timing, so its bus is retimed first;
  // limitation: read data must settle three cycles before the strobe ends.
  // Only the second stage is read; the first may be metastable.
  logic [DATA_WIDTH-1:0] data_meta;
  logic [DATA_WIDTH-1:0] data_sync;
  always_ff @(posedge sys_clk) begin
    data_meta <= data_in;
    data_sync <= data_meta;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_WGAP,
    ST_READ,
    ST_RGAP
  } dpsf_state_type;

  dpsf_state_type state, next_state;
  logic [3:0] count, next_count;
  dpsf_cmd_type cur, next_cur;
  logic wr_bit, next_wr_bit;
  logic [INDEX_WIDTH:0] init_left, next_init_left;
  logic done_q, next_done;
  logic granted_q, next_granted;
  logic [DATA_WIDTH-1:0] word_q, next_word;
  // Pin outputs are registered so no combinational glitch reaches the device
  dpsf_pins_type pins_q, next_pins;
  logic data_oe_q, next_data_oe;
  logic [DATA_WIDTH-1:0] data_out_q, next_data_out;

  always_comb begin
    next_state = state;
    next_count = count;
    next_cur = cur;
    next_wr_bit = wr_bit;
    next_init_left = init_left;
    next_done = 1'b0;
    next_granted = granted_q;
    next_word = word_q;
    next_pins = pins_q;
    next_data_oe = data_oe_q;
    next_data_out = data_out_q;
    case (state)
      ST_IDLE: begin
        // Pins rest deselected so neither strobe is seen between commands
        next_pins = PINS_IDLE;
        next_data_oe = 1'b0;
        if (cmd_valid) begin
          next_cur = cmd;
          next_count = COUNT_RESET;
          next_init_left = 4'(TOKEN_COUNT - 1);
          if (cmd.op == OP_POLL) begin
            next_state = ST_READ;
          end else begin
            // Acquire writes zero, release and init write one
            next_wr_bit = (cmd.op == OP_ACQUIRE) ? FLAG_TAKEN : FLAG_FREE;
            next_state = ST_WRITE;
          end
          if (cmd.op == OP_INIT) begin
            next_cur.index = 3'h0;
          end
        end
      end
      ST_WRITE: begin
        // Select low with write strobe; only bit zero carries the value
        next_pins = '{1'b0, 1'b1, 1'b0, cur.index};
        next_data_oe = 1'b1;
        next_data_out = {{(DATA_WIDTH-1){1'b0}}, wr_bit};
        next_count = count + 4'h1;
        if (count == STROBE_CYCLES - 4'h1) begin
          next_count = COUNT_RESET;
          next_state = ST_WGAP;
        end
      end
      ST_WGAP: begin
        // Select goes high between accesses so the next one starts cleanly
        next_pins = PINS_IDLE;
        next_data_oe = 1'b0;
        next_count = count + 4'h1;
        if (count == GAP_CYCLES - 4'h1) begin
          next_count = COUNT_RESET;
          // Init walks every index so no stale request survives power-up
          if (cur.op == OP_INIT && init_left != 4'h0) begin
            next_init_left = init_left - 4'h1;
            next_cur.index = cur.index + 3'h1;
            next_state = ST_WRITE;
          end else if (cur.op == OP_ACQUIRE) begin
            // Claim is confirmed only by reading back after the write
            next_state = ST_READ;
          end else begin
            // A freed or reinitialised token is no longer ours
            next_done = 1'b1;
            next_granted = 1'b0;
            next_state = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        // The device freezes the flag once select and enable are both low
        next_pins = '{1'b0, 1'b0, 1'b1, cur.index};
        next_data_oe = 1'b0;
        next_count = count + 4'h1;
        if (count == STROBE_CYCLES - 4'h1) begin
          next_count = COUNT_RESET;
          next_word = data_sync;
          // Zero read means this side owns it; the device's arbiter decides
          next_granted = (data_sync[0] == FLAG_TAKEN);
          next_state = ST_RGAP;
        end
      end
      ST_RGAP: begin
        // Select dropped so the next poll sees a fresh value
        next_pins = PINS_IDLE;
        next_data_oe = 1'b0;
        next_count = count + 4'h1;
        if (count == GAP_CYCLES - 4'h1) begin
          next_count = COUNT_RESET;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        // Unreachable; recover to idle
        next_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  // Synchronous reset: pins return deselected within one edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      count <= COUNT_RESET;
      cur <= '0;
      wr_bit <= FLAG_FREE;
      init_left <= 4'h0;
      done_q <= 1'b0;
      granted_q <= 1'b0;
      word_q <= '0;
      pins_q <= PINS_IDLE;
      data_oe_q <= 1'b0;
      data_out_q <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
      cur <= next_cur;
      wr_bit <= next_wr_bit;
      init_left <= next_init_left;
      done_q <= next_done;
      granted_q <= next_granted;
      word_q <= next_word;
      pins_q <= next_pins;
      data_oe_q <= next_data_oe;
      data_out_q <= next_data_out;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Ready is combinational so a new command can be taken on the done cycle
  assign cmd_ready = (state == ST_IDLE);
  assign done = done_q;
  assign granted = granted_q;
  assign read_word = word_q;
  assign pins = pins_q;
  assign data_oe = data_oe_q;
  assign data_out = data_out_q;
endmodule
`default_nettype wire
